// File: design/rtca_alarm_match.sv
`timescale 1ns/1ns
`include "rtca_cfg.svh"
module rtca_alarm_match
  import rtca_pkg::*;
#(
  parameter int ALARM_IDX = 0
) (
  input  wire rtca_sel_t  alarm_match_select,
  input  wire logic [5:0] hour_val,
  input  wire logic [2:0] weekday_value,
  input  wire logic [5:0] date_val,
  input  wire logic [7:0] cur_hour,
  input  wire logic [2:0] cur_weekday,
  input  wire logic [5:0] cur_date,
  input  wire logic       sec_equal,
  input  wire logic       min_equal,
  input  wire logic       hsec_equal,
  input  wire logic       month_equal,
  output logic            hit
);

  logic hour_eq;
  logic weekday_value_eq;
  logic date_eq;
  logic month_ok;

  //----------------------------------------
  // Field comparisons
  //----------------------------------------
  // Hour compare follows the live 12/24 setting
  always_comb begin
    if (cur_hour[`RTCA_FMT_BIT]) begin
      hour_eq = (hour_val[`RTCA_MERID_BIT] == cur_hour[`RTCA_MERID_BIT])
             && (hour_val[`RTCA_TEN12_BIT] == cur_hour[`RTCA_TEN12_BIT])
             && (hour_val[`RTCA_ONES_HI:0] == cur_hour[`RTCA_ONES_HI:0]);
    end else begin
      hour_eq = (hour_val[`RTCA_TEN24_HI:`RTCA_TEN24_LO]
                 == cur_hour[`RTCA_TEN24_HI:`RTCA_TEN24_LO])
             && (hour_val[`RTCA_ONES_HI:0] == cur_hour[`RTCA_ONES_HI:0]);
    end
  end

  assign weekday_value_eq = (weekday_value == cur_weekday);
  assign date_eq  = (date_val == cur_date);
  // Month has no comparator on alarm 1, so it never gates there
  assign month_ok = (ALARM_IDX == 0) ? month_equal : 1'b1;

  //----------------------------------------
  // Select decode
  //----------------------------------------
  // Reserved codes never match, so a stray setting stays silent
  always_comb begin
    case (alarm_match_select)
      `RTCA_SEL_SEC:   hit = sec_equal;
      `RTCA_SEL_MIN:   hit = min_equal;
      `RTCA_SEL_HOUR:  hit = hour_eq;
      `RTCA_SEL_WEEKDAY_VALUE: hit = weekday_value_eq;
      `RTCA_SEL_DATE:  hit = date_eq;
      `RTCA_SEL_HSEC:  hit = (ALARM_IDX == 1) && hsec_equal;
      `RTCA_SEL_ALL:   hit = sec_equal && min_equal && hour_eq && weekday_value_eq
                             && date_eq && month_ok;
      default:         hit = 1'b0;
    endcase
  end

endmodule : rtca_alarm_match

// File: design/rtca_alarm_regs.sv
`timescale 1ns/1ns
`include "rtca_cfg.svh"
module rtca_alarm_regs
  import rtca_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       osc_tick,
  input  wire logic [1:0] alarm_enable,
  input  wire logic [7:0] timekeeping_hour_reg,
  input  wire logic [2:0] cur_weekday,
  input  wire logic [5:0] cur_date,
  input  wire logic [1:0] sec_equal,
  input  wire logic [1:0] min_equal,
  input  wire logic [1:0] hsec_equal,
  input  wire logic       month_equal,
  output logic      [1:0] alarm_to_irq,
  output logic      [1:0] alarm_to_wdo
);

  localparam logic [1:0][7:0] HOUR_ADDR  = {`RTCA_ADDR_HOUR1, `RTCA_ADDR_HOUR0};
  localparam logic [1:0][7:0] WEEKDAY_VALUE_ADDR = {`RTCA_ADDR_WKDAY1, `RTCA_ADDR_WKDAY0};
  localparam logic [1:0][7:0] DATE_ADDR  = {`RTCA_ADDR_DATE1, `RTCA_ADDR_DATE0};

  rtca_state_s      st;
  rtca_state_s      next_st;
  logic       [1:0] hit;
  logic       [1:0] flag;

  //----------------------------------------
  // Per-alarm comparators and pin routing
  //----------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    rtca_alarm_match #(
      .ALARM_IDX(i)
    ) u_match (
      .alarm_match_select(st.weekday_value_cfg[i][`RTCA_SEL_HI:`RTCA_SEL_LO]),
      .hour_val          (st.hour_val[i]),
      .weekday_value     (st.weekday_value_cfg[i][`RTCA_WEEKDAY_VALUE_HI:0]),
      .date_val          (st.date_val[i]),
      .cur_hour          (timekeeping_hour_reg),
      .cur_weekday       (cur_weekday),
      .cur_date          (cur_date),
      .sec_equal         (sec_equal[i]),
      .min_equal         (min_equal[i]),
      .hsec_equal        (hsec_equal[i]),
      .month_equal       (month_equal),
      .hit               (hit[i])
    );
    assign flag[i] = st.weekday_value_cfg[i][`RTCA_FLAG_BIT];
    // Each alarm steers its own flag to exactly one pin
    assign alarm_to_irq[i] = flag[i] && !st.weekday_value_cfg[i][`RTCA_PIN_BIT];
    assign alarm_to_wdo[i] = flag[i] &&  st.weekday_value_cfg[i][`RTCA_PIN_BIT];
  end

  //----------------------------------------
  // Next state: register writes, reads, match flags
  //----------------------------------------
  always_comb begin
    next_st = st;
    for (int i = 0; i < 2; i++) begin
      if (reg_wr) begin
        if (reg_addr == HOUR_ADDR[i]) begin
          // Bit 6 is never stored; bit 7 is dropped
          next_st.hour_val[i] = reg_wdata[`RTCA_VAL_HI:0];
        end else if (reg_addr == WEEKDAY_VALUE_ADDR[i]) begin
          next_st.weekday_value_cfg[i] = reg_wdata;
          // Writes may only clear the flag
          next_st.weekday_value_cfg[i][`RTCA_FLAG_BIT] = flag[i] && reg_wdata[`RTCA_FLAG_BIT];
        end else if (reg_addr == DATE_ADDR[i]) begin
          next_st.date_val[i] = reg_wdata[`RTCA_VAL_HI:0];
        end
      end
      // Set beats a same-cycle clear; only software ever clears
      if (osc_tick && alarm_enable[i] && hit[i]) begin
        next_st.weekday_value_cfg[i][`RTCA_FLAG_BIT] = 1'b1;
      end
    end
    if (reg_rd) begin
      next_st.rdata = `RTCA_RST_RDATA;
      for (int i = 0; i < 2; i++) begin
        if (reg_addr == HOUR_ADDR[i]) begin
          next_st.rdata = {1'b0, timekeeping_hour_reg[`RTCA_FMT_BIT], st.hour_val[i]};
        end else if (reg_addr == WEEKDAY_VALUE_ADDR[i]) begin
          next_st.rdata = st.weekday_value_cfg[i];
        end else if (reg_addr == DATE_ADDR[i]) begin
          next_st.rdata = {2'b00, st.date_val[i]};
        end
      end
    end
  end

  //----------------------------------------
  // State register
  //----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st.weekday_value_cfg <= {`RTCA_RST_WEEKDAY_VALUE, `RTCA_RST_WEEKDAY_VALUE};
      st.date_val  <= {`RTCA_RST_DATE, `RTCA_RST_DATE};
      st.hour_val  <= {`RTCA_RST_HOUR, `RTCA_RST_HOUR};
      st.rdata     <= `RTCA_RST_RDATA;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;

endmodule : rtca_alarm_regs

// File: design/rtca_cfg.svh
`ifndef RTCA_CFG_SVH
`define RTCA_CFG_SVH

//----------------------------------------
// Register offsets
//----------------------------------------
`define RTCA_ADDR_HOUR0  8'h0e
`define RTCA_ADDR_WKDAY0 8'h0f
`define RTCA_ADDR_DATE0  8'h10
`define RTCA_ADDR_HOUR1  8'h15
`define RTCA_ADDR_WKDAY1 8'h16
`define RTCA_ADDR_DATE1  8'h17

//----------------------------------------
// Reset values
//----------------------------------------
`define RTCA_RST_HOUR    6'h00
`define RTCA_RST_WEEKDAY_VALUE   8'h01
`define RTCA_RST_DATE    6'h01
`define RTCA_RST_RDATA   8'h00

//----------------------------------------
// Field positions
//----------------------------------------
`define RTCA_PIN_BIT     7
`define RTCA_SEL_HI      6
`define RTCA_SEL_LO      4
`define RTCA_FLAG_BIT    3
`define RTCA_WEEKDAY_VALUE_HI    2
`define RTCA_FMT_BIT     6
`define RTCA_MERID_BIT   5
`define RTCA_TEN12_BIT   4
`define RTCA_TEN24_HI    5
`define RTCA_TEN24_LO    4
`define RTCA_ONES_HI     3
`define RTCA_VAL_HI      5

//----------------------------------------
// Match select encodings
//----------------------------------------
`define RTCA_SEL_SEC     3'h0
`define RTCA_SEL_MIN     3'h1
`define RTCA_SEL_HOUR    3'h2
`define RTCA_SEL_WEEKDAY_VALUE   3'h3
`define RTCA_SEL_DATE    3'h4
`define RTCA_SEL_HSEC    3'h5
`define RTCA_SEL_RSVD    3'h6
`define RTCA_SEL_ALL     3'h7

`endif

// File: design/rtca_pkg.sv
package rtca_pkg;

  typedef logic [2:0] rtca_sel_t;

  // Whole register state of the alarm block
  typedef struct packed {
    logic [1:0][7:0] weekday_value_cfg;
    logic [1:0][5:0] date_val;
    logic [1:0][5:0] hour_val;
    logic [7:0]      rdata;
  } rtca_state_s;

endpackage : rtca_pkg

// File: dv/rtca_alarm_regs_assertions.sv
`timescale 1ns/1ns
// Register port and flag checks, fed from the top ports only
module rtca_alarm_regs_chk import rtca_pkg::*; (
  input logic       mclk,
  input logic       rstn,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_rdata,
  input logic       osc_tick,
  input logic [1:0] alarm_enable,
  input logic [7:0] timekeeping_hour_reg,
  input logic [1:0] alarm_to_irq,
  input logic [1:0] alarm_to_wdo
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Read data is tied to its source as sampled on the read edge
  a_hour_fmt: assert property (reg_rd && reg_addr == 8'h0e |=>
    reg_rdata[7:6] == {1'b0, $past(timekeeping_hour_reg[6])}) else $error("hour format bit wrong");
  a_date_top: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata[7:6] == 2'b00)
    else $error("date top bits set");
  a_flag_read: assert property (reg_rd && reg_addr == 8'h0f |=>
    reg_rdata[3] == $past(alarm_to_irq[0] | alarm_to_wdo[0])) else $error("flag readback wrong");
  // A flag only rises on an enabled tick and only falls on a write
  a_flag_hold: assert property (alarm_to_irq[0] && !(reg_wr && reg_addr == 8'h0f) |=> alarm_to_irq[0])
    else $error("flag dropped by itself");
  a_no_sw_set: assert property (!osc_tick && !(alarm_to_irq[0] | alarm_to_wdo[0]) |=>
    !(alarm_to_irq[0] | alarm_to_wdo[0])) else $error("flag set without tick");
  a_tick_zero: assert property ($rose(alarm_to_irq[0] | alarm_to_wdo[0]) |->
    $past(osc_tick && alarm_enable[0])) else $error("alarm 0 rose without enabled tick");
  a_tick_one: assert property ($rose(alarm_to_irq[1] | alarm_to_wdo[1]) |->
    $past(osc_tick && alarm_enable[1])) else $error("alarm 1 rose without enabled tick");
  a_route_excl: assert property ((alarm_to_irq & alarm_to_wdo) == 2'b00)
    else $error("alarm on both pins");
endmodule : rtca_alarm_regs_chk
bind rtca_alarm_regs rtca_alarm_regs_chk u_chk (.*);

// File: dv/rtca_alarm_regs_tb_top.sv
`timescale 1ns/1ns
module rtca_alarm_regs_tb_top
  import rtca_pkg::*;
();
  logic       mclk, rstn, reg_wr, reg_rd, osc_tick, month_equal, hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, timekeeping_hour_reg, base;
  logic [1:0] alarm_enable, sec_equal, min_equal, hsec_equal, alarm_to_irq, alarm_to_wdo;
  logic [2:0] cur_weekday;
  logic [5:0] cur_date;
  int         num_errors = 0;
  int         checks_done = 0;
  localparam logic [2:0] w_op = 3'b100, r_op = 3'b010, t_op = 3'b001;
  rtca_alarm_regs dut (.*);
  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Case equality, so an unknown never passes
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One write, read or tick; falling-edge drive keeps clear of the sampling edge
  task automatic acc(input logic [2:0] c, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    {reg_wr, reg_rd, osc_tick, reg_addr, reg_wdata} = {c, a, d};
    @(negedge mclk);
    {reg_wr, reg_rd, osc_tick} = 3'b000;
    if (c[1]) chk(reg_rdata, d);
  endtask : acc
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  // Hang guard, about four and a half times the expected run
  initial begin
    #20000;
    num_errors++;
    summarize();
  end
  // Reset, then layout, select and hour tests
  initial begin
    {rstn, reg_wr, reg_rd, osc_tick, month_equal, reg_addr, reg_wdata} = '0;
    {timekeeping_hour_reg, cur_weekday, cur_date} = {8'h00, 3'h1, 6'h12};
    {alarm_enable, sec_equal, min_equal, hsec_equal} = 8'hff;
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    acc(r_op, 8'h0e, 8'h00);
    for (int i = 0; i < 4; i++) acc(r_op, (i[1] ? 8'h16 : 8'h0f) + 8'(i[0]), 8'h01);
    acc(w_op, 8'h15, 8'hff);
    acc(r_op, 8'h15, 8'h3f);
    timekeeping_hour_reg = 8'h40;
    acc(r_op, 8'h15, 8'h7f);
    acc(w_op, 8'h10, 8'hff);
    acc(r_op, 8'h10, 8'h3f);
    acc(r_op, 8'h00, 8'h00);
    $display("test layout done");
    // Every select code on both alarms, month equal and not
    timekeeping_hour_reg = 8'h00;
    for (int k = 0; k < 32; k++) begin
      base = k[3] ? 8'h15 : 8'h0e;
      hit = k[2:0] != 6 && (k[3] || (k[2:0] != 5 && (k[2:0] != 7 || k[4])));
      {month_equal, alarm_enable} = {k[4], 2'b01 << k[3]};
      acc(w_op, base, 8'h00);
      acc(w_op, base + 8'h2, 8'h12);
      acc(w_op, base + 8'h1, {1'b0, k[2:0], 4'h1});
      acc(t_op, 8'h00, 8'h00);
      acc(r_op, base + 8'h1, {1'b0, k[2:0], hit, 3'h1});
      chk({6'h0, alarm_to_irq}, {7'h0, hit} << k[3]);
      acc(w_op, base + 8'h1, 8'h01);
    end
    $display("test match select done");
    alarm_enable = 2'b01;
    timekeeping_hour_reg = 8'h65;
    acc(w_op, 8'h0e, 8'h25);
    acc(w_op, 8'h0f, 8'ha9);
    acc(r_op, 8'h0f, 8'ha1);
    acc(t_op, 8'h00, 8'h00);
    acc(r_op, 8'h0f, 8'ha9);
    chk({4'h0, alarm_to_wdo, alarm_to_irq}, 8'h04);
    acc(w_op, 8'h0f, 8'ha1);
    acc(w_op, 8'h0e, 8'h05);
    acc(t_op, 8'h00, 8'h00);
    acc(r_op, 8'h0f, 8'ha1);
    $display("test hour and route done");
    summarize();
  end
endmodule : rtca_alarm_regs_tb_top
